// >>> design/pfc_consts.svh
// constants for the parallel flash host controller
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH
`define PFC_ADDR_UNLOCK1 20'h0_5555
`define PFC_ADDR_UNLOCK2 20'h0_2AAA
`define PFC_DATA_UNLOCK1 8'hAA
`define PFC_DATA_UNLOCK2 8'h55
`define PFC_CMD_RESET    8'hF0
`define PFC_CMD_IDENT    8'h90
`define PFC_CMD_PROGRAM  8'hA0
`define PFC_CMD_ERASE    8'h80
`define PFC_CMD_CHIP     8'h10
`define PFC_CMD_SECTOR   8'h30
`define PFC_CMD_SUSPEND  8'hB0
`define PFC_CMD_RESUME   8'h30
`define PFC_ID_PROTECT   8'h02
`define PFC_POLL_LIMIT   16'hFFFF
// each strobe phase lasts this many clocks (3 x 10 ns)
`define PFC_PHASE_CYC    2'h3
`endif

// >>> design/pfc_pkg.sv
// types of the parallel flash host controller
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_OP_READ    = 3'b000,
    PFC_OP_RESET   = 3'b001,
    PFC_OP_IDENT   = 3'b010,
    PFC_OP_PROGRAM = 3'b011,
    PFC_OP_CHIP    = 3'b100,
    PFC_OP_SECTOR  = 3'b101,
    PFC_OP_SUSPEND = 3'b110,
    PFC_OP_RESUME  = 3'b111
  } pfc_op_t;
  typedef enum logic [2:0] {
    PFC_ST_IDLE  = 3'b000,
    PFC_ST_SETUP = 3'b001,
    PFC_ST_PULSE = 3'b010,
    PFC_ST_HOLD  = 3'b011,
    PFC_ST_POLL  = 3'b100,
    PFC_ST_DONE  = 3'b101
  } pfc_state_t;
endpackage

// >>> design/pfc_seq_rom.sv
// command sequence table: address and data of each bus write step
`timescale 1ns/1ps
`include "pfc_consts.svh"
module pfc_seq_rom
  import pfc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire pfc_op_t    op,
  input  wire logic [2:0] step,
  input  wire logic [19:0] user_addr,
  input  wire logic [7:0] user_data,
  output logic [19:0]     seq_addr,
  output logic [7:0]      seq_data,
  output logic [2:0]      seq_len
);
  logic [19:0] addr_next;
  logic [7:0]  data_next;
  logic [2:0]  len_next;
  wire         unlock_a = (step == 3'h0) || (step == 3'h3);
  wire         unlock_b = (step == 3'h1) || (step == 3'h4);

  // table lookup; bits 19..16 of unlock addresses left zero
  always_comb
  begin
    addr_next = `PFC_ADDR_UNLOCK1;
    data_next = `PFC_DATA_UNLOCK1;
    len_next  = 3'h3;
    if (unlock_b)
    begin
      addr_next = `PFC_ADDR_UNLOCK2;
      data_next = `PFC_DATA_UNLOCK2;
    end
    case (op)
      PFC_OP_RESET:   if (step == 3'h2) data_next = `PFC_CMD_RESET;
      PFC_OP_IDENT:   if (step == 3'h2) data_next = `PFC_CMD_IDENT;
      PFC_OP_PROGRAM:
      begin
        len_next = 3'h4;
        if (step == 3'h2) data_next = `PFC_CMD_PROGRAM;
        if (step == 3'h3)
        begin
          addr_next = user_addr;
          data_next = user_data;
        end
      end
      PFC_OP_CHIP, PFC_OP_SECTOR:
      begin
        len_next = 3'h6;
        if (step == 3'h2) data_next = `PFC_CMD_ERASE;
        if (step == 3'h5)
        begin
          addr_next = (op == PFC_OP_CHIP) ? `PFC_ADDR_UNLOCK1 : user_addr;
          data_next = (op == PFC_OP_CHIP) ? `PFC_CMD_CHIP : `PFC_CMD_SECTOR;
        end
      end
      PFC_OP_SUSPEND, PFC_OP_RESUME:
      begin
        len_next  = 3'h1;
        addr_next = user_addr;
        data_next = (op == PFC_OP_SUSPEND) ? `PFC_CMD_SUSPEND : `PFC_CMD_RESUME;
      end
      default:
      begin
        addr_next = user_addr;
        data_next = `PFC_CMD_RESET;
        len_next  = 3'h1;
      end
    endcase
    if (!unlock_a && !unlock_b && op == PFC_OP_READ) addr_next = user_addr;
  end

  // registered table output
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_addr <= 20'h0_0000;
      seq_data <= 8'h00;
      seq_len  <= 3'h1;
    end
    else
    begin
      seq_addr <= addr_next;
      seq_data <= data_next;
      seq_len  <= len_next;
    end
  end
endmodule

// >>> design/pfc_host.sv
// host controller driving a byte-wide parallel flash through its pins
`timescale 1ns/1ps
`include "pfc_consts.svh"
module pfc_host
  import pfc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire pfc_op_t     cmd_op,
  input  wire logic [19:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_error,
  input  wire logic        flash_reset_req,
  output logic [19:0]      flash_addr,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe_n,
  input  wire logic [7:0]  flash_dq_in,
  output logic             chip_select_n,
  output logic             write_strobe_n,
  output logic             output_gate_n,
  output logic             flash_reset_n
);
  logic        rst_s1_reg;
  logic        rst_s2_reg;
  wire         rst_int_n = rst_s2_reg;
  pfc_state_t  state_reg;
  pfc_state_t  state_next;
  pfc_op_t     op_reg;
  logic [19:0] addr_reg;
  logic [7:0]  data_reg;
  logic [2:0]  step_reg;
  logic [1:0]  phase_reg;
  logic [15:0] poll_reg;
  logic [7:0]  rsp_data_reg;
  logic        rsp_valid_reg;
  logic        rsp_error_reg;
  logic [19:0] seq_addr;
  logic [7:0]  seq_data;
  logic [2:0]  seq_len;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  pfc_seq_rom u_rom (
    .ref_clk   (ref_clk),
    .rst_n     (rst_int_n),
    .op        (op_reg),
    .step      (step_reg),
    .user_addr (addr_reg),
    .user_data (data_reg),
    .seq_addr  (seq_addr),
    .seq_data  (seq_data),
    .seq_len   (seq_len)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire is_read    = (op_reg == PFC_OP_READ);
  wire is_write   = !is_read;
  wire phase_end  = (phase_reg == `PFC_PHASE_CYC - 2'h1);
  wire last_step  = (step_reg == seq_len - 3'h1);
  wire needs_poll = (op_reg == PFC_OP_PROGRAM) || (op_reg == PFC_OP_CHIP)
                    || (op_reg == PFC_OP_SECTOR);
  // program done when bit7 equals written bit; erase done when bit7 is one
  wire poll_bit   = (op_reg == PFC_OP_PROGRAM) ? data_reg[7] : 1'b1;
  wire poll_match = (flash_dq_in[7] == poll_bit);
  wire poll_fail  = flash_dq_in[5] && !poll_match; // time-limit flag
  wire poll_out   = (poll_reg == `PFC_POLL_LIMIT);
  // protected target: caller's business, reported as error; a reset abort gives no response

  assign cmd_ready     = (state_reg == PFC_ST_IDLE) && rst_int_n;
  assign rsp_valid     = rsp_valid_reg;
  assign rsp_data      = rsp_data_reg;
  assign rsp_error     = rsp_error_reg;
  // pin low forces the device back to array read
  assign flash_reset_n = rst_int_n && !flash_reset_req;
  // one strobe pulse in the middle phase; oe stays high on writes
  assign chip_select_n  = !((state_reg == PFC_ST_SETUP) || (state_reg == PFC_ST_PULSE)
                            || (state_reg == PFC_ST_HOLD) || (state_reg == PFC_ST_POLL));
  assign write_strobe_n = !(is_write && state_reg == PFC_ST_PULSE);
  assign output_gate_n  = !((is_read && state_reg == PFC_ST_PULSE)
                            || state_reg == PFC_ST_POLL);
  assign flash_dq_oe_n  = !(is_write && state_reg != PFC_ST_IDLE
                            && state_reg != PFC_ST_POLL && state_reg != PFC_ST_DONE);
  assign flash_addr     = (state_reg == PFC_ST_POLL) ? addr_reg : seq_addr;
  assign flash_dq_out   = seq_data;

  ////////////////////////////////////////////////////////////////////////
  // sequencer: each bus cycle is setup, pulse, hold of PHASE_CYC clocks
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PFC_ST_IDLE:  if (cmd_valid) state_next = PFC_ST_SETUP;
      PFC_ST_SETUP: if (phase_end) state_next = PFC_ST_PULSE;
      PFC_ST_PULSE: if (phase_end) state_next = PFC_ST_HOLD;
      PFC_ST_HOLD:
        if (phase_end)
        begin
          if (!last_step) state_next = PFC_ST_SETUP;
          else if (needs_poll) state_next = PFC_ST_POLL; // no writes while busy
          else state_next = PFC_ST_DONE;
        end
      PFC_ST_POLL:
        if (phase_end && (poll_match || poll_fail || poll_out)) state_next = PFC_ST_DONE;
      PFC_ST_DONE:  state_next = PFC_ST_IDLE;
      default:      state_next = PFC_ST_IDLE;
    endcase
    if (flash_reset_req) state_next = PFC_ST_IDLE; // abort; target undefined
  end

  // state, step and phase counters
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      state_reg <= PFC_ST_IDLE;
      phase_reg <= 2'h0;
      step_reg  <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= (state_next != state_reg || phase_end) ? 2'h0 : phase_reg + 2'h1;
      if (state_reg == PFC_ST_IDLE) step_reg <= 3'h0;
      else if (state_reg == PFC_ST_HOLD && phase_end && !last_step)
        step_reg <= step_reg + 3'h1;
    end
  end

  // command capture; any address order is accepted
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      op_reg   <= PFC_OP_READ;
      addr_reg <= 20'h0_0000;
      data_reg <= 8'h00;
    end
    else if (cmd_ready && cmd_valid)
    begin
      op_reg   <= cmd_op;
      addr_reg <= cmd_addr;
      data_reg <= cmd_data;
    end
  end

  // poll counter and response
  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      poll_reg      <= 16'h0000;
      rsp_valid_reg <= 1'b0;
      rsp_error_reg <= 1'b0;
      rsp_data_reg  <= 8'h00;
    end
    else
    begin
      rsp_valid_reg <= (state_reg == PFC_ST_DONE);
      if (state_reg != PFC_ST_POLL) poll_reg <= 16'h0000;
      else if (phase_end && poll_reg != `PFC_POLL_LIMIT) poll_reg <= poll_reg + 16'h0001;
      if (is_read && state_reg == PFC_ST_PULSE && phase_end) rsp_data_reg <= flash_dq_in;
      if (state_reg == PFC_ST_POLL && phase_end)
      begin
        rsp_data_reg  <= flash_dq_in;
        rsp_error_reg <= !poll_match;
      end
      else if (state_reg == PFC_ST_IDLE) rsp_error_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_we_oe_exclusive;
    @(posedge ref_clk) disable iff (!rst_int_n)
    !write_strobe_n |-> (!chip_select_n && output_gate_n);
  endproperty
  a_we_oe_exclusive: assert property (p_we_oe_exclusive)
    else $error("write strobe without select or with gate low");

  // an abort by the reset request may cut the pulse short
  property p_we_width;
    @(posedge ref_clk) disable iff (!rst_int_n || flash_reset_req)
    $fell(write_strobe_n) |-> (!write_strobe_n)[*3] ##1 write_strobe_n;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write pulse not three clocks");

  property p_data_stable;
    @(posedge ref_clk) disable iff (!rst_int_n)
    !write_strobe_n |=> $stable(flash_dq_out) || write_strobe_n;
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("data moved during write pulse");

  property p_unlock_first;
    @(posedge ref_clk) disable iff (!rst_int_n)
    ($fell(write_strobe_n) && step_reg == 3'h0 && seq_len != 3'h1)
      |-> (flash_dq_out == `PFC_DATA_UNLOCK1 && flash_addr == `PFC_ADDR_UNLOCK1);
  endproperty
  a_unlock_first: assert property (p_unlock_first)
    else $error("first write is not unlock");

  property p_no_write_poll;
    @(posedge ref_clk) disable iff (!rst_int_n)
    (state_reg == PFC_ST_POLL) |-> write_strobe_n;
  endproperty
  a_no_write_poll: assert property (p_no_write_poll)
    else $error("write while device busy");

  property p_reset_pin;
    @(posedge ref_clk) disable iff (!rst_int_n)
    flash_reset_req |-> !flash_reset_n ##1 (state_reg == PFC_ST_IDLE);
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset request not honoured");

  property p_erase_len;
    @(posedge ref_clk) disable iff (!rst_int_n)
    (state_reg == PFC_ST_SETUP && (op_reg == PFC_OP_CHIP || op_reg == PFC_OP_SECTOR)
      && step_reg != 3'h0) |-> seq_len == 3'h6;
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase sequence length wrong");

  property p_done_rsp;
    @(posedge ref_clk) disable iff (!rst_int_n)
    (state_reg == PFC_ST_DONE) |=> rsp_valid ##1 !rsp_valid;
  endproperty
  a_done_rsp: assert property (p_done_rsp)
    else $error("response not a one clock pulse");

  c_program: cover property (@(posedge ref_clk) disable iff (!rst_int_n)
    op_reg == PFC_OP_PROGRAM && state_reg == PFC_ST_DONE);
  c_erase: cover property (@(posedge ref_clk) disable iff (!rst_int_n)
    op_reg == PFC_OP_SECTOR && state_reg == PFC_ST_DONE);
  c_read: cover property (@(posedge ref_clk) disable iff (!rst_int_n)
    is_read && rsp_valid);
endmodule

// >>> sim/pfc_flash_model.sv
// behavioural byte-wide flash device seen across the controller's pins
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter logic [7:0] PROT  = 8'h00, // groups ship unprotected
  parameter logic [7:0] MK_ID = 8'h13, // arbitrary value, odd parity
  parameter logic [7:0] PT_ID = 8'hB5, // arbitrary value, odd parity
  parameter int         POLLS = 3
) (
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  dq_w,
  output logic      [7:0]  dq_r,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        rst_pin_n,
  input  wire logic        hv
);
  logic [7:0]  mem [logic [19:0]];
  logic [19:0] a_lat = '0;
  logic [19:0] tgt   = '0;
  logic [7:0]  tgt_d = '0;
  logic        ident = 1'b0; // power-up state is array read
  logic        arm   = 1'b0;
  logic        busy  = 1'b0;
  logic        fail  = 1'b0;
  logic        wr    = 1'b0;
  int          step  = 0;
  int          polls = 0;
  int          bad_wr = 0;
  logic [7:0]  rv;
  wire         u1 = a_lat[10:0] == 11'h555; // bits 19..11 ignored
  wire         u2 = a_lat[10:0] == 11'h2AA;
  // identification page: maker, part, group protect bit
  wire  [7:0]  idv = addr[6] ? 8'h00 : addr[1:0] == 2'b00 ? MK_ID : addr[1:0] == 2'b01 ?
                     PT_ID : {7'h00, PROT[addr[19:17]] & ~addr[0]};
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  function automatic logic lock(input logic [19:0] a);
    return PROT[a[19:17]] && !hv;
  endfunction
  task automatic erase(input logic whole, input logic [3:0] sec);
    foreach (mem[k])
      if (!lock(k) && (whole || k[19:16] == sec))
        mem[k] = 8'hFF;
    fail = whole ? 1'b0 : lock({sec, 16'h0000});
    tgt_d = 8'hFF;
    busy = 1'b1;
    polls = 0;
  endtask
  ////////////////////////////////////////////////////////////////
  // address taken on the later falling strobe
  always @(negedge we_n or negedge cs_n)
  begin
    if (!we_n && !cs_n)
    begin
      a_lat = addr;
      wr = 1'b1;
      if (oe_n !== 1'b1)
        bad_wr++;
    end
  end
  // command decoder, data taken on the first rising strobe
  always @(posedge we_n or posedge cs_n)
  begin
    int s;
    s = step;
    step = 0;
    if (wr && rst_pin_n && !busy) // no writes while busy
    begin
      if (s == 3)
      begin
        tgt = a_lat;
        tgt_d = dq_w;
        fail = lock(a_lat) || |(dq_w & ~rd(a_lat));
        if (!lock(a_lat))
          mem[a_lat] = rd(a_lat) & dq_w;
        busy = 1'b1;
        polls = 0;
      end
      else if (arm && s == 2 && u1 && dq_w == 8'h10)
        erase(1'b1, 4'h0);
      else if (arm && s == 2 && dq_w == 8'h30)
        erase(1'b0, a_lat[19:16]);
      else if (dq_w == 8'hF0)
        ident = 1'b0;
      else if (s == 0 && u1 && dq_w == 8'hAA)
        step = 1;
      else if (s == 1 && u2 && dq_w == 8'h55)
        step = 2;
      else if (s == 2 && u1 && dq_w == 8'h90 && !arm)
        ident = 1'b1;
      else if (s == 2 && u1 && dq_w == 8'hA0 && !arm)
        step = 3;
      else if (s == 2 && u1 && dq_w == 8'h80)
        step = 4;
      arm = step == 4 || (arm && step != 0); // stray write drops the sequence
      if (step == 4)
        step = 0;
    end
    wr = 1'b0;
  end
  // read path; a released bus shows the inverse so stale data never passes
  assign rv = (busy && (fail || polls < POLLS)) ? {~tgt_d[7], 1'b0, fail, 5'h00} :
              ident ? idv : rd(addr);
  assign dq_r = (!oe_n && !cs_n) ? rv : ~rv;
  // the controller keeps oe low through the whole poll, so progress is timed
  always #30
    if (busy && !oe_n && polls < POLLS)
      polls++;
  // status stays up until the poll read is released
  always @(posedge oe_n)
  begin
    if (busy && (polls >= POLLS || fail))
      busy = 1'b0; // back to read mode
  end
  // reset pin: back to read, half-entered sequence lost
  always @(negedge rst_pin_n)
  begin
    if (busy && tgt_d != 8'hFF)
      mem[tgt] = ~tgt_d; // target left corrupted
    ident = 1'b0;
    arm = 1'b0;
    busy = 1'b0;
    step = 0;
    wr = 1'b0;
  end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
`include "pfc_consts.svh"
`define CHK(nm, ex, sn) \
  begin \
    tests_run++; \
    if ((sn) !== (ex)) \
    begin \
      err_total++; \
      $display("Error %s expected %h seen %h", nm, ex, sn); \
    end \
  end
module testbench
  import pfc_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  pfc_op_t     cmd_op = PFC_OP_READ;
  logic [19:0] cmd_addr = '0;
  logic [7:0]  cmd_data = '0;
  logic        flash_reset_req = 1'b0;
  logic        hv = 1'b0;
  logic        cmd_ready, rsp_valid, rsp_error, flash_dq_oe_n, got_e;
  logic        chip_select_n, write_strobe_n, output_gate_n, flash_reset_n;
  logic [7:0]  rsp_data, flash_dq_out, dq_r, got_d;
  logic [19:0] flash_addr;
  int          err_total = 0;
  int          tests_run = 0;
  int          wr_cnt = 0;
  int          rsp_cnt = 0;
  wire  [7:0]  flash_dq_in = flash_dq_oe_n ? dq_r : flash_dq_out;
  always #5 ref_clk = ~ref_clk;
  always @(negedge write_strobe_n) wr_cnt++;
  always @(posedge ref_clk) if (rsp_valid === 1'b1) rsp_cnt++;
  pfc_host DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
    .flash_reset_req(flash_reset_req), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
    .flash_reset_n(flash_reset_n));
  pfc_flash_model #(.PROT(8'h04)) flash_dev (.addr(flash_addr), .dq_w(flash_dq_out),
    .dq_r(dq_r), .cs_n(chip_select_n), .we_n(write_strobe_n), .oe_n(output_gate_n),
    .rst_pin_n(flash_reset_n), .hv(hv));
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic stuck();
    err_total++;
    $display("Error handshake expected done seen timeout");
    final_report();
  endtask
  // requests change at the falling edge and drop after the taking edge
  task automatic issue(input pfc_op_t op, input logic [19:0] a, input logic [7:0] d);
    int i;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    for (i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    if (i == 40) stuck();
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic run(input pfc_op_t op, input logic [19:0] a, input logic [7:0] d);
    int i;
    wr_cnt = 0;
    issue(op, a, d);
    for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 400) stuck();
    got_d = rsp_data;
    got_e = rsp_error;
    @(negedge ref_clk);
  endtask
  task automatic chk_rd(input string nm, input logic [19:0] a, input logic [7:0] ex);
    run(PFC_OP_READ, a, 8'h00);
    `CHK(nm, ex, got_d)
  endtask
  task automatic pg(input string nm, input logic [19:0] a, input logic [7:0] d, input logic e);
    run(PFC_OP_PROGRAM, a, d);
    `CHK(nm, e, got_e)
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_prog();
    chk_rd("boot read", 20'h0_1234, 8'hFF);
    pg("prog hi", 20'h3_FFFF, 8'hA5, 1'b0);
    `CHK("prog writes", 4, wr_cnt)
    pg("prog lo", 20'h1_0000, 8'h3C, 1'b0);
    chk_rd("read hi", 20'h3_FFFF, 8'hA5);
    chk_rd("read lo", 20'h1_0000, 8'h3C);
    pg("set bits", 20'h3_FFFF, 8'hFF, 1'b1);
    chk_rd("still zero", 20'h3_FFFF, 8'hA5);
  endtask
  task automatic t_ident();
    run(PFC_OP_IDENT, 20'h0_0000, 8'h00);
    `CHK("ident writes", 3, wr_cnt)
    chk_rd("maker", 20'h0_0000, 8'h13);
    chk_rd("part", 20'h0_0001, 8'hB5);
    `CHK("parity", 1'b1, ^got_d)
    chk_rd("grp on", 20'h4_8002, 8'h01);
    chk_rd("grp off", 20'h6_0002, 8'h00);
    chk_rd("stays", 20'h3_F800, 8'h13);
    run(PFC_OP_RESET, 20'h0_0000, 8'h00);
    `CHK("reset writes", 3, wr_cnt)
    chk_rd("array", 20'h3_FFFF, 8'hA5);
    chk_rd("array again", 20'h1_0000, 8'h3C);
  endtask
  task automatic t_protect();
    pg("locked", 20'h4_0010, 8'h55, 1'b1);
    chk_rd("locked read", 20'h4_0010, 8'hFF);
    hv = 1'b1;
    pg("lifted", 20'h4_0010, 8'h55, 1'b0);
    chk_rd("lifted read", 20'h4_0010, 8'h55);
    hv = 1'b0;
    pg("relocked", 20'h5_0020, 8'h00, 1'b1);
    chk_rd("relocked read", 20'h5_0020, 8'hFF);
  endtask
  task automatic t_erase();
    run(PFC_OP_SECTOR, 20'h3_0040, 8'h00);
    `CHK("sector writes", 6, wr_cnt)
    chk_rd("sector gone", 20'h3_FFFF, 8'hFF);
    chk_rd("other kept", 20'h1_0000, 8'h3C);
    run(PFC_OP_CHIP, 20'h0_0000, 8'h00);
    chk_rd("chip gone", 20'h1_0000, 8'hFF);
    chk_rd("group kept", 20'h4_0010, 8'h55);
    run(PFC_OP_SUSPEND, 20'h0_0000, 8'h00);
    `CHK("suspend writes", 1, wr_cnt)
    run(PFC_OP_RESUME, 20'h4_0000, 8'h00);
    `CHK("resume writes", 1, wr_cnt)
    chk_rd("no erase", 20'h4_0010, 8'h55);
  endtask
  // reset request in mid-program: no answer, device usable afterwards
  task automatic t_abort();
    int n;
    n = rsp_cnt;
    issue(PFC_OP_PROGRAM, 20'h2_0000, 8'h00);
    repeat (12) @(negedge ref_clk);
    flash_reset_req = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("pin reset", 1'b0, flash_reset_n)
    flash_reset_req = 1'b0;
    repeat (10) @(negedge ref_clk);
    `CHK("no answer", n, rsp_cnt)
    pg("after abort", 20'h2_0000, 8'h81, 1'b0);
    chk_rd("abort read", 20'h2_0000, 8'h81);
  endtask
  initial
  begin
    repeat (4) @(negedge ref_clk);
    `CHK("reset pins", 4'hE, {chip_select_n, write_strobe_n, output_gate_n, flash_reset_n})
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    t_prog();
    t_ident();
    t_protect();
    t_erase();
    t_abort();
    `CHK("write qualify", 0, flash_dev.bad_wr)
    final_report();
  end
endmodule
